// [hdl/energy_pulse_accumulator.v]
// metering back end: energy accumulation, pulse outputs, mode decode
// assumes powers arrive already scaled and synchronous; mode pins are async
`timescale 1ns/1ns
`include "energy_pulse_map.vh"
// Notes on behaviour
// - add power once per 1 MHz tick
// - resolution is 0.01 pulse constant
// - signed net accumulator; overflow counts forward/reverse
// - update energy register per selected step
// - whole pulse: pulse out, direction flags
// - sum phases per five mode bits
// - first output from total active energy
// - second output reactive or apparent energy
// - third fundamental, fourth harmonic active energy
// - 80 ms high, or half period
// - below 10 ms: stretch, 5 ms high
// - accumulate only above startup threshold
// - drop phase under no-load threshold
// - no-load flags, no pulses, start no-load
// - average over 16 voltage cycles
// - frequency source A, else C, else B
// - temperature sample every 100 ms
// - mode from two pins only
// - normal mode runs everything but detector
// - idle: all off, serial pins input, osc low; neutral current and frequency source still update
// - apparent power is vrms times irms
// - neutral current is phase current sum
// - bit 9 picks tenths or hundredths
module energy_pulse_accumulator (
  // clock and reset
  input  wire               clk_i,
  input  wire               sys_rst_i,
  // mode pins from the controller
  input  wire               mode_select_low_i,
  input  wire               mode_select_high_i,
  // configuration
  input  wire [15:0]        metering_config_zero_i,
  input  wire [31:0]        pulse_energy_constant_i,
  input  wire [31:0]        active_startup_threshold_i,
  input  wire [31:0]        reactive_startup_threshold_i,
  input  wire [31:0]        apparent_startup_threshold_i,
  input  wire [31:0]        phase_noload_threshold_i,
  // per-phase computed quantities, a,b,c packed low to high
  input  wire signed [95:0] phase_active_i,
  input  wire signed [95:0] phase_reactive_i,
  input  wire signed [95:0] phase_fund_i,
  input  wire signed [95:0] phase_harm_i,
  input  wire        [47:0] phase_vrms_i,
  input  wire        [47:0] phase_irms_i,
  input  wire signed [47:0] phase_inst_current_i,
  input  wire        [2:0]  phase_sag_i,
  input  wire               voltage_cycle_i,
  input  wire        [15:0] temp_sensor_i,
  // pulse outputs
  output reg                active_energy_pulse_out_o,
  output reg                reactive_apparent_pulse_out_o,
  output reg                fundamental_energy_pulse_out_o,
  output reg                harmonic_energy_pulse_out_o,
  // energy registers, units of 0.01 or 0.1 pulse
  output reg  [31:0]        active_fwd_energy_o,
  output reg  [31:0]        active_rev_energy_o,
  output reg  [31:0]        react_fwd_energy_o,
  output reg  [31:0]        react_rev_energy_o,
  // status
  output reg  [15:0]        system_status_second_o,
  output reg  [15:0]        energy_status_zero_o,
  output reg  [1:0]         power_mode_o,
  output reg  [1:0]         freq_source_o,
  output reg  [15:0]        temperature_o,
  output reg                averages_ready_o,
  output reg  signed [35:0] mean_active_total_o,
  output reg  [63:0]        mean_apparent_total_o,
  output reg  signed [17:0] neutral_current_o,
  // pin control
  output reg                serial_out_enable_o,
  output reg                oscillator_drive_out_o
);
  localparam S_IDLE = 4'h1, S_DET = 4'h2, S_PART = 4'h4, S_NORM = 4'h8;
  localparam [31:0] TEMP_CYC = `TEMP_PERIOD_MS * `MS_CYCLES;

  // two-flop sync of the mode pins
  reg [1:0] pm_meta_q, pm_q;
  reg [3:0] state_q;
  reg [3:0] state_d;
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pm_meta_q <= `MODE_IDLE;
      pm_q      <= `MODE_IDLE;
    end else begin
      pm_meta_q <= {mode_select_high_i, mode_select_low_i};
      pm_q      <= pm_meta_q;
    end
  end
  always @* begin
    case (pm_q)
      `MODE_NORMAL:  state_d = S_NORM;
      `MODE_PARTIAL: state_d = S_PART;
      `MODE_DETECT:  state_d = S_DET;
      default:       state_d = S_IDLE;
    endcase
  end
  wire normal   = state_q == S_NORM;
  wire wake     = (state_d == S_NORM) && !normal;
  wire clear_en = wake;

  // 1 MHz tick
  reg [5:0] div_q;
  wire tick = normal && div_q == `TICK_DIV - 1;
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i)
      div_q <= 6'h0;
    else if (!normal || tick)
      div_q <= 6'h0;
    else
      div_q <= div_q + 6'h1;
  end

  // phase gating and summing
  reg signed [33:0] p_sum, q_sum, f_sum, h_sum;
  reg        [33:0] s_sum;
  reg signed [31:0] pa, qa, fa, ha;
  reg        [31:0] sa, ap, aq;
  reg        [2:0]  live;
  integer k;
  always @* begin
    p_sum = 34'sh0;
    q_sum = 34'sh0;
    f_sum = 34'sh0;
    h_sum = 34'sh0;
    s_sum = 34'h0;
    live  = 3'h0;
    for (k = 0; k < 3; k = k + 1) begin
      pa = phase_active_i[k*32 +: 32];
      qa = phase_reactive_i[k*32 +: 32];
      fa = phase_fund_i[k*32 +: 32];
      ha = phase_harm_i[k*32 +: 32];
      sa = phase_vrms_i[k*16 +: 16] * phase_irms_i[k*16 +: 16];
      ap = pa[31] ? -pa : pa;
      aq = qa[31] ? -qa : qa;
      live[k] = metering_config_zero_i[k] &&
                ({1'b0, ap} + {1'b0, aq} >= {1'b0, phase_noload_threshold_i});
      if (live[k]) begin
        p_sum = p_sum + (metering_config_zero_i[`CFG_ABS_P] ? $signed({2'b00, ap}) : {{2{pa[31]}}, pa});
        q_sum = q_sum + (metering_config_zero_i[`CFG_ABS_Q] ? $signed({2'b00, aq}) : {{2{qa[31]}}, qa});
        f_sum = f_sum + {{2{fa[31]}}, fa};
        h_sum = h_sum + {{2{ha[31]}}, ha};
        s_sum = s_sum + {2'b00, sa};
      end
    end
  end
  wire [33:0] p_mag = p_sum[33] ? -p_sum : p_sum;
  wire [33:0] q_mag = q_sum[33] ? -q_sum : q_sum;
  wire p_run = p_mag > {2'b00, active_startup_threshold_i};
  wire q_run = q_mag > {2'b00, reactive_startup_threshold_i};
  wire s_run = s_sum > {2'b00, apparent_startup_threshold_i};
  wire cf2_app = metering_config_zero_i[`CFG_CF2_APPARENT];

  // four accumulation channels: active, reactive/apparent, fundamental, harmonic
  wire [135:0] chan_pow = {h_sum, f_sum, cf2_app ? s_sum : q_sum, p_sum};
  wire [3:0]   chan_run = {p_run, p_run, cf2_app ? s_run : q_run, p_run};
  wire [3:0]   step_fwd, step_rev, whole;
  wire [3:0]   pulse_w;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : chan
      reg signed [40:0] acc_q;   // signed net, within +/- one 0.01 step
      reg [6:0]         hund_q;  // hundredths toward a whole pulse
      reg               dir_q;   // direction of the running whole pulse
      wire signed [40:0] pw  = {{7{chan_pow[g*34+33]}}, chan_pow[g*34 +: 34]};
      wire signed [40:0] nxt = acc_q + pw;
      wire signed [40:0] lim = $signed({9'h0, pulse_energy_constant_i});
      wire fwd = tick && chan_run[g] && nxt >= lim;
      wire rev = tick && chan_run[g] && nxt <= -lim;
      assign step_fwd[g] = fwd;
      assign step_rev[g] = rev;
      assign whole[g] = (fwd || rev) && hund_q == `HUNDREDTHS - 1;
      always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          acc_q  <= 41'sh0;
          hund_q <= 7'h0;
          dir_q  <= 1'b0;
        end else if (clear_en) begin
          acc_q  <= 41'sh0;
          hund_q <= 7'h0;
          dir_q  <= 1'b0;
        end else if (tick && chan_run[g]) begin
          acc_q <= fwd ? nxt - lim : rev ? nxt + lim : nxt;
          if (fwd || rev) begin
            dir_q  <= rev;
            hund_q <= whole[g] ? 7'h0 : hund_q + 7'h1;
          end
        end
      end
      pulse_shaper shaper (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .clear_i   (clear_en),
        .fire_i    (whole[g] && chan_run[g]),
        .pulse_o   (pulse_w[g])
      );
    end
  endgenerate

  // resolution step for the energy registers
  reg [3:0] fsub_q [0:1];
  reg [3:0] rsub_q [0:1];
  wire tenths = metering_config_zero_i[`CFG_RES_SEL];

  reg [4:0]  cyc_q;
  reg [31:0] tmr_q;
  reg signed [35:0] avg_p_q;
  reg        [63:0] avg_s_q;
  integer j;
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= S_IDLE;
      active_energy_pulse_out_o      <= 1'b0;
      reactive_apparent_pulse_out_o  <= 1'b0;
      fundamental_energy_pulse_out_o <= 1'b0;
      harmonic_energy_pulse_out_o    <= 1'b0;
      active_fwd_energy_o <= 32'h0;
      active_rev_energy_o <= 32'h0;
      react_fwd_energy_o  <= 32'h0;
      react_rev_energy_o  <= 32'h0;
      system_status_second_o <= 16'h0;
      energy_status_zero_o   <= 16'hC000;
      power_mode_o   <= `MODE_IDLE;
      freq_source_o  <= `FREQ_SRC_A;
      temperature_o  <= 16'h0;
      averages_ready_o <= 1'b0;
      mean_active_total_o   <= 36'sh0;
      mean_apparent_total_o <= 64'h0;
      neutral_current_o     <= 18'sh0;
      serial_out_enable_o   <= 1'b0;
      oscillator_drive_out_o <= 1'b0;
      cyc_q   <= 5'h0;
      tmr_q   <= 32'h0;
      avg_p_q <= 36'sh0;
      avg_s_q <= 64'h0;
      for (j = 0; j < 2; j = j + 1) begin
        fsub_q[j] <= 4'h0;
        rsub_q[j] <= 4'h0;
      end
    end else begin
      state_q <= state_d;
      power_mode_o <= pm_q;
      // idle: outputs low, serial out released, oscillator held low
      serial_out_enable_o    <= normal;
      oscillator_drive_out_o <= normal ? ~oscillator_drive_out_o : 1'b0;
      active_energy_pulse_out_o      <= normal && pulse_w[0];
      reactive_apparent_pulse_out_o  <= normal && pulse_w[1];
      fundamental_energy_pulse_out_o <= normal && pulse_w[2];
      harmonic_energy_pulse_out_o    <= normal && pulse_w[3];
      if (normal) begin
        energy_status_zero_o[14] <= !p_run;
        energy_status_zero_o[15] <= !(cf2_app ? s_run : q_run);
      end else
        energy_status_zero_o[15:14] <= 2'h3;
      // direction flags refresh on each active and reactive whole pulse
      if (whole[0])
        system_status_second_o[0] <= step_rev[0];
      if (whole[1])
        system_status_second_o[4] <= step_rev[1];
      // energy register steps, sub-counters count hundredths toward a tenth
      for (j = 0; j < 2; j = j + 1) begin
        if (step_fwd[j]) begin
          if (!tenths || fsub_q[j] == `TENTH_STEPS - 1) begin
            fsub_q[j] <= 4'h0;
            if (j == 0) active_fwd_energy_o <= active_fwd_energy_o + 32'h1;
            else        react_fwd_energy_o  <= react_fwd_energy_o + 32'h1;
          end else
            fsub_q[j] <= fsub_q[j] + 4'h1;
        end
        if (step_rev[j]) begin
          if (!tenths || rsub_q[j] == `TENTH_STEPS - 1) begin
            rsub_q[j] <= 4'h0;
            if (j == 0) active_rev_energy_o <= active_rev_energy_o + 32'h1;
            else        react_rev_energy_o  <= react_rev_energy_o + 32'h1;
          end else
            rsub_q[j] <= rsub_q[j] + 4'h1;
        end
      end
      // frequency source by sag state
      if (!phase_sag_i[0])      freq_source_o <= `FREQ_SRC_A;
      else if (!phase_sag_i[2]) freq_source_o <= `FREQ_SRC_C;
      else                      freq_source_o <= `FREQ_SRC_B;
      // neutral current from instantaneous sum
      neutral_current_o <= {{2{phase_inst_current_i[15]}}, phase_inst_current_i[15:0]}
                         + {{2{phase_inst_current_i[31]}}, phase_inst_current_i[31:16]}
                         + {{2{phase_inst_current_i[47]}}, phase_inst_current_i[47:32]};
      // temperature sampling
      if (normal && tmr_q >= TEMP_CYC - 1) begin
        tmr_q <= 32'h0;
        temperature_o <= temp_sensor_i;
      end else if (normal)
        tmr_q <= tmr_q + 32'h1;
      // 16-cycle averages, result is sum shifted by four
      averages_ready_o <= 1'b0;
      if (normal && voltage_cycle_i) begin
        if (cyc_q == `AVG_CYCLES - 1) begin
          cyc_q <= 5'h0;
          // signed cast keeps the shift arithmetic for reverse power
          mean_active_total_o   <= $signed(avg_p_q + {{2{p_sum[33]}}, p_sum}) >>> 4;
          mean_apparent_total_o <= (avg_s_q + {30'h0, s_sum}) >> 4;
          avg_p_q <= 36'sh0;
          avg_s_q <= 64'h0;
          averages_ready_o <= 1'b1;
        end else begin
          cyc_q   <= cyc_q + 5'h1;
          avg_p_q <= avg_p_q + {{2{p_sum[33]}}, p_sum};
          avg_s_q <= avg_s_q + {30'h0, s_sum};
        end
      end
    end
  end
endmodule // energy_pulse_accumulator

// [hdl/energy_pulse_map.vh]
// constants for the energy pulse accumulator back end
// assumes a 50 MHz system clock and plain-port control bits
`ifndef ENERGY_PULSE_MAP_VH
`define ENERGY_PULSE_MAP_VH
`define CLK_HZ            50000000
`define TICK_HZ           1000000
`define TICK_DIV          (`CLK_HZ / `TICK_HZ)
`define MS_CYCLES         (`CLK_HZ / 1000)
`define PULSE_MIN_PER_MS  10
`define PULSE_MIN_HI_MS   5
`define PULSE_LONG_MS     160
`define PULSE_LONG_HI_MS  80
`define AVG_CYCLES        5'h10
`define TEMP_PERIOD_MS    100
`define HUNDREDTHS        7'h64
`define TENTH_STEPS       4'hA
`define MODE_NORMAL       2'h3
`define MODE_PARTIAL      2'h2
`define MODE_DETECT       2'h1
`define MODE_IDLE         2'h0
`define CFG_EN_PA         0
`define CFG_EN_PB         1
`define CFG_EN_PC         2
`define CFG_ABS_P         3
`define CFG_ABS_Q         4
`define CFG_RES_SEL       9
`define CFG_CF2_APPARENT  10
`define FREQ_SRC_A        2'h0
`define FREQ_SRC_B        2'h1
`define FREQ_SRC_C        2'h2
`endif

// [hdl/pulse_shaper.v]
// one pulse output with period-dependent high time
// assumes one-cycle whole-pulse requests from the accumulator channel
`timescale 1ns/1ns
`include "energy_pulse_map.vh"
module pulse_shaper (
  // clock and reset
  input  wire        clk_i,
  input  wire        sys_rst_i,
  input  wire        clear_i,
  // request
  input  wire        fire_i,
  output reg         pulse_o
);
  localparam [31:0] MS = `MS_CYCLES;
  reg [31:0] since_q;   // cycles since last pulse start, saturating
  reg [31:0] hi_q;      // remaining high cycles
  reg [31:0] gap_q;     // remaining forced-spacing cycles
  reg        pend_q;    // request waiting out the minimum period
  wire [31:0] per_ms = since_q / MS;
  wire [31:0] hi_len = (per_ms >= `PULSE_LONG_MS) ? `PULSE_LONG_HI_MS * MS :
                       (since_q >> 1);
  wire go = (fire_i | pend_q) && gap_q == 32'h0;
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      since_q <= 32'hFFFFFFFF;
      hi_q    <= 32'h0;
      gap_q   <= 32'h0;
      pend_q  <= 1'b0;
      pulse_o <= 1'b0;
    end else if (clear_i) begin
      since_q <= 32'hFFFFFFFF;
      hi_q    <= 32'h0;
      gap_q   <= 32'h0;
      pend_q  <= 1'b0;
      pulse_o <= 1'b0;
    end else begin
      // a request inside the 10 ms window waits; the period stretches
      pend_q <= (fire_i | pend_q) & ~go;
      if (go) begin
        since_q <= 32'h1;
        gap_q   <= `PULSE_MIN_PER_MS * MS - 1;
        hi_q    <= (since_q < `PULSE_MIN_PER_MS * MS) ? `PULSE_MIN_HI_MS * MS - 1 : hi_len - 1;
        pulse_o <= 1'b1;
      end else begin
        if (since_q != 32'hFFFFFFFF)
          since_q <= since_q + 32'h1;
        if (gap_q != 32'h0)
          gap_q <= gap_q - 32'h1;
        if (hi_q != 32'h0)
          hi_q <= hi_q - 32'h1;
        else
          pulse_o <= 1'b0;
      end
    end
  end
endmodule // pulse_shaper

// [sim/energy_pulse_accumulator_test.sv]
// bench for the energy pulse accumulator: modes, sums, pulses
// assumes the controller model and the bound checker
`timescale 1ns/1ns
module energy_pulse_accumulator_test;
  reg         clk_i = 1'b0;
  reg         sys_rst_i = 1'b1;
  reg  [1:0]  mode_req = 2'h0;
  reg  [15:0] cfg = 16'h0;
  reg  [95:0] pw = 96'h0;
  reg  [95:0] pf = 96'h0;
  reg  [47:0] vr = 48'h0;
  reg  [47:0] ir = 48'h0;
  reg  [47:0] ic = 48'h0;
  reg  [2:0]  sag = 3'h0;
  reg         vc = 1'b0;
  reg  [31:0] seed = 32'h61;
  reg  [31:0] e0, e1, e2, e3;
  reg  signed [17:0] en_x;
  reg  [63:0] ap_x;
  wire        pm_lo, pm_hi, cf1, cf2, cf3, cf4, avr, soe, osc;
  wire [31:0] afe, are, rfe, rre;
  wire [15:0] s2, s0, pc;
  wire [1:0]  pm, fs;
  wire [63:0] mapp;
  wire signed [17:0] nc;
  wire signed [35:0] mat;
  integer     st = 0, nt = 0, bad_count = 0, n_tests = 0, cyc = 0, n_avg = 0, i, j, np, nq;
  mode_controller_model mcu (.clk_i(clk_i), .mode_req_i(mode_req), .mode_select_low_o(pm_lo),
    .mode_select_high_o(pm_hi), .pulse_i(cf1), .pulse_count_o(pc));
  energy_pulse_accumulator DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .mode_select_low_i(pm_lo),
    .mode_select_high_i(pm_hi), .metering_config_zero_i(cfg), .pulse_energy_constant_i(32'h3E8),
    .active_startup_threshold_i(st), .reactive_startup_threshold_i(st), .apparent_startup_threshold_i(st),
    .phase_noload_threshold_i(nt), .phase_active_i(pw), .phase_reactive_i(pw), .phase_fund_i(pf),
    .phase_harm_i(pf), .phase_vrms_i(vr), .phase_irms_i(ir), .phase_inst_current_i(ic), .phase_sag_i(sag),
    .voltage_cycle_i(vc), .temp_sensor_i(16'h1234), .active_energy_pulse_out_o(cf1),
    .reactive_apparent_pulse_out_o(cf2), .fundamental_energy_pulse_out_o(cf3), .harmonic_energy_pulse_out_o(cf4),
    .active_fwd_energy_o(afe), .active_rev_energy_o(are), .react_fwd_energy_o(rfe), .react_rev_energy_o(rre),
    .system_status_second_o(s2), .energy_status_zero_o(s0), .power_mode_o(pm), .freq_source_o(fs),
    .temperature_o(), .averages_ready_o(avr), .mean_active_total_o(mat), .mean_apparent_total_o(mapp),
    .neutral_current_o(nc), .serial_out_enable_o(soe), .oscillator_drive_out_o(osc));
  function [31:0] xs(input [31:0] x);
    reg [31:0] y;
    begin
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      xs = y ^ (y << 5);
    end
  endfunction
  // summed power per tick after phase exclusion and startup gating
  function integer net_of(input [95:0] p, input [2:0] en, input ab);
    integer q, v;
    begin
      net_of = 0;
      for (q = 0; q < 3; q = q + 1) begin
        v = $signed(p[q*32+:32]);
        if (v < 0 && ab) v = -v;
        if (en[q] && 2 * (v < 0 ? -v : v) >= nt) net_of = net_of + v;
      end
      if (net_of <= st && -net_of <= st) net_of = 0;
    end
  endfunction
  // 100 ticks at constant 1000: net/10 hundredths, net/100 tenths
  function [31:0] dexp(input integer n, input tenth);
    dexp = n > 0 ? n / (tenth ? 100 : 10) : 0;
  endfunction
  task wt(input integer n);
    repeat (n) @(posedge clk_i);
  endtask
  task chk(input [63:0] exp, input [63:0] got, input [8*8:1] nm);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("BAD %0s exp %0h got %0h", nm, exp, got);
      end
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc = cyc + 1;
    if (avr) n_avg = n_avg + 1;
    if (cyc == 95000) begin
      bad_count = bad_count + 1;
      end_of_test;
    end
  end
  initial begin
    wt(8);
    sys_rst_i <= 1'b0;
    wt(2);
    chk(16'hC000, s0, "status0");
    chk(0, {cf1, cf2, cf3, cf4, soe, osc, pm}, "rst_out");
    for (i = 1; i < 4; i = i + 1) begin
      mode_req <= i[1:0];
      wt(8);
      chk(i, pm, "mode");
      chk(i == 3, soe, "sdo_en");
      mode_req <= 2'h0;
      wt(8);
      chk(0, {soe, osc, pm}, "idle");
    end
    mode_req <= 2'h3;
    wt(200);
    chk(0, pc, "no_pulse");
    chk(16'hC000, s0 & 16'hC000, "noload");
    $display("mode test done");
    for (i = 0; i < 8; i = i + 1) begin
      sag <= i[2:0];
      wt(10);
      chk(!i[0] ? 0 : (!i[2] ? 2 : 1), fs, "freq");
    end
    seed = xs(seed);
    ic <= {seed[23:0], seed[31:8]};
    vr <= {seed[15:0], seed};
    ir <= {seed, seed[15:0]};
    // all phases live so the apparent sum covers a, b and c
    cfg <= 16'h0007;
    pw <= {3{32'hFFFFFF38}};
    wt(10);
    en_x = $signed(ic[15:0]) + $signed(ic[31:16]) + $signed(ic[47:32]);
    ap_x = vr[15:0] * ir[15:0] + vr[31:16] * ir[31:16] + vr[47:32] * ir[47:32];
    chk(en_x, nc, "neutral");
    n_avg = 0;
    repeat (48) begin
      vc <= 1'b1;
      wt(1);
      vc <= 1'b0;
      wt(19);
    end
    wt(20);
    chk(3, n_avg, "avg_cnt");
    chk(ap_x, mapp, "apparent");
    chk(64'hFFFFFFFFFFFFFDA8, mat, "mean_p");
    $display("measure test done");
    for (i = 0; i < 10; i = i + 1) begin
      for (j = 0; j < 3; j = j + 1) begin
        seed = xs(seed);
        pw[j*32+:32] <= (seed % 7 - 3) * 100;
      end
      seed = xs(seed);
      cfg <= {6'h0, seed[5], 4'h0, seed[4:0]};
      st <= seed[6] ? 5000 : 0;
      nt <= seed[7] ? 250 : 0;
      wt(1000);
      e0 = afe;
      e1 = are;
      e2 = rfe;
      e3 = rre;
      wt(5000);
      np = net_of(pw, cfg[2:0], cfg[3]);
      nq = net_of(pw, cfg[2:0], cfg[4]);
      chk(dexp(np, cfg[9]), afe - e0, "act_fwd");
      chk(dexp(-np, cfg[9]), are - e1, "act_rev");
      chk(dexp(nq, cfg[9]), rfe - e2, "re_fwd");
      chk(dexp(-nq, cfg[9]), rre - e3, "re_rev");
      chk({nq == 0, np == 0}, s0[15:14], "noload");
    end
    $display("energy test done");
    cfg <= 16'h0001;
    st <= 0;
    nt <= 0;
    pw <= {64'h0, 32'hFFFFFC18};
    pf <= {64'h0, 32'hFFFFFC18};
    wt(6500);
    chk(4'hF, {cf1, cf2, cf3, cf4}, "pulses");
    chk(2'h3, {s2[4], s2[0]}, "rev_flag");
    mode_req <= 2'h0;
    wt(10);
    chk(0, {cf1, cf2, cf3, cf4}, "idle_cf");
    pw <= 96'h0;
    pf <= 96'h0;
    mode_req <= 2'h3;
    wt(400);
    chk(0, {cf1, cf2, cf3, cf4}, "wake_cf");
    $display("pulse test done");
    end_of_test;
  end
endmodule // energy_pulse_accumulator_test

// [sim/energy_pulse_checker_sva.sv]
// assertions on the energy pulse accumulator ports
// assumes one clock domain and the constants header
`timescale 1ns/1ns
`include "energy_pulse_map.vh"
module energy_pulse_checker (
  // clock and reset
  input wire        clk_i,
  input wire        sys_rst_i,
  // inputs
  input wire        mode_select_low_i,
  input wire        mode_select_high_i,
  input wire [15:0] metering_config_zero_i,
  input wire [2:0]  phase_sag_i,
  input wire        voltage_cycle_i,
  // outputs
  input wire        active_energy_pulse_out_o,
  input wire        reactive_apparent_pulse_out_o,
  input wire        fundamental_energy_pulse_out_o,
  input wire        harmonic_energy_pulse_out_o,
  input wire [31:0] active_fwd_energy_o,
  input wire [31:0] active_rev_energy_o,
  input wire [15:0] energy_status_zero_o,
  input wire [1:0]  power_mode_o,
  input wire [1:0]  freq_source_o,
  input wire        averages_ready_o,
  input wire        serial_out_enable_o,
  input wire        oscillator_drive_out_o
);
  // a resolution switch may rescale counts, so steps are judged only later
  reg  [15:0] cfg_q;
  reg  [7:0]  age_q;
  wire [7:0]  age_d = (metering_config_zero_i != cfg_q) ? 8'h0 : (age_q == 8'hFF ? age_q : age_q + 8'h1);
  wire        old_cfg = age_q > 8'hC8;
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cfg_q <= 16'h0;
      age_q <= 8'h0;
    end else begin
      cfg_q <= metering_config_zero_i;
      age_q <= age_d;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  mode_follows_pins_a: assert property ($stable({mode_select_high_i, mode_select_low_i})[*4] |->
    power_mode_o == {mode_select_high_i, mode_select_low_i}) else $error("mode does not follow pins");
  idle_pins_off_a: assert property ((power_mode_o != `MODE_NORMAL)[*3] |->
    !serial_out_enable_o && !oscillator_drive_out_o) else $error("pin drive outside normal mode");
  osc_runs_normal_a: assert property ((power_mode_o == `MODE_NORMAL)[*3] |->
    ##[1:64] $changed(oscillator_drive_out_o)) else $error("oscillator still in normal mode");
  pulses_off_idle_a: assert property ((power_mode_o == `MODE_IDLE)[*3] |-> !(active_energy_pulse_out_o ||
    reactive_apparent_pulse_out_o || fundamental_energy_pulse_out_o || harmonic_energy_pulse_out_o))
    else $error("pulse output high in idle");
  fwd_step_one_a: assert property (old_cfg && $changed(active_fwd_energy_o) |->
    active_fwd_energy_o == $past(active_fwd_energy_o) + 32'h1) else $error("forward count jumped");
  rev_step_one_a: assert property (old_cfg && $changed(active_rev_energy_o) |->
    active_rev_energy_o == $past(active_rev_energy_o) + 32'h1) else $error("reverse count jumped");
  pulse_needs_load_a: assert property ($rose(active_energy_pulse_out_o) |->
    $past(power_mode_o, 2) == `MODE_NORMAL && !$past(energy_status_zero_o[14], 3)) else $error("pulse without load");
  freq_source_sel_a: assert property (($stable(phase_sag_i) && power_mode_o == `MODE_NORMAL)[*4] |->
    freq_source_o == (!phase_sag_i[0] ? `FREQ_SRC_A : (!phase_sag_i[2] ? `FREQ_SRC_C : `FREQ_SRC_B)))
    else $error("wrong frequency source");
  avg_after_cycle_a: assert property (averages_ready_o |-> ($past(voltage_cycle_i, 1) ||
    $past(voltage_cycle_i, 2) || $past(voltage_cycle_i, 3)) ##1 !averages_ready_o) else $error("stray average");
endmodule // energy_pulse_checker
bind energy_pulse_accumulator energy_pulse_checker u_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .mode_select_low_i(mode_select_low_i), .mode_select_high_i(mode_select_high_i),
  .metering_config_zero_i(metering_config_zero_i), .phase_sag_i(phase_sag_i), .voltage_cycle_i(voltage_cycle_i),
  .active_energy_pulse_out_o(active_energy_pulse_out_o), .reactive_apparent_pulse_out_o(reactive_apparent_pulse_out_o),
  .fundamental_energy_pulse_out_o(fundamental_energy_pulse_out_o),
  .harmonic_energy_pulse_out_o(harmonic_energy_pulse_out_o), .active_fwd_energy_o(active_fwd_energy_o),
  .active_rev_energy_o(active_rev_energy_o), .energy_status_zero_o(energy_status_zero_o),
  .power_mode_o(power_mode_o), .freq_source_o(freq_source_o), .averages_ready_o(averages_ready_o),
  .serial_out_enable_o(serial_out_enable_o), .oscillator_drive_out_o(oscillator_drive_out_o));

// [sim/mode_controller_model.sv]
// far-side controller: drives the two mode pins, counts active pulses
// assumes requests from the bench change on a rising edge
`timescale 1ns/1ns
module mode_controller_model (
  // clock
  input  wire        clk_i,
  // request from the bench
  input  wire [1:0]  mode_req_i,
  // mode pins and pulse input
  output reg         mode_select_low_o,
  output reg         mode_select_high_o,
  input  wire        pulse_i,
  output reg  [15:0] pulse_count_o
);
  reg pulse_q;
  initial begin
    mode_select_low_o = 1'b0;
    mode_select_high_o = 1'b0;
    pulse_count_o = 16'h0;
    pulse_q = 1'b0;
  end
  // pins always at valid levels, both bits move on one edge
  always @(posedge clk_i) begin
    {mode_select_high_o, mode_select_low_o} <= mode_req_i;
    pulse_q <= pulse_i;
    if (pulse_i && !pulse_q) pulse_count_o <= pulse_count_o + 16'h1;
  end
endmodule // mode_controller_model
